// ===== include/acs_map.svh
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// Register byte offsets and word indices
`define ACS_ADAPT_IDX 12'h001
`define ACS_ADAPT_OFF 12'h004
`define ACS_RUN_OFF 12'h010
`define ACS_DIV1_OFF 12'h014
`define ACS_DIV2_OFF 12'h018
`define ACS_OSR_OFF 12'h01C
`define ACS_STAT_OFF 12'h024
`define ACS_UCM_IDX 12'h03A
`define ACS_UCM_OFF 12'h0E8

// Coefficient windows, one per buffer
`define ACS_COEF_A_PAGE 4'h1
`define ACS_COEF_B_PAGE 4'h2

// Adaptive control field positions
`define ACS_SWAP_BIT 0
`define ACS_INUSE_BIT 1
`define ACS_ADAPT_BIT 2

// Unused-input common-mode field
`define ACS_UCM_LSB 2
`define ACS_UCM_MSB 7

// Reset values
`define ACS_DIV_RST 7'h01
`define ACS_OSR_RST 8'h40
`define ACS_UCM_RST 6'h00

// AXI response codes
`define ACS_RESP_OKAY 2'h0
`define ACS_RESP_SLVERR 2'h2

`endif

// ===== include/acs_pkg.sv
package acs_pkg;

	// How a host coefficient access is treated
	typedef enum logic [1:0]
	{
		ACS_ACC_DIRECT = 2'b00,
		ACS_ACC_REDIRECT = 2'b01,
		ACS_ACC_LOCKED = 2'b10
	} acs_access_t;

	// Buffer identifier
	typedef enum logic
	{
		ACS_BUF_A = 1'b0,
		ACS_BUF_B = 1'b1
	} acs_buf_t;

endpackage : acs_pkg

// ===== hw/acs_coef_store.sv
`timescale 1ns/1ps

// Two full copies of the coefficient set with host and engine ports
module acs_coef_store #(
	parameter int COEF_N = 64,
	parameter int COEF_W = 24,
	parameter int AW = 6
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Host write port
	input wire logic wr_en,
	input wire acs_pkg::acs_buf_t wr_buf,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [COEF_W-1:0] wr_data,
	// Host read port, combinational
	input wire acs_pkg::acs_buf_t rd_buf,
	input wire logic [AW-1:0] rd_addr,
	output logic [COEF_W-1:0] rd_data,
	// Filter engine read port, registered
	input wire acs_pkg::acs_buf_t eng_buf,
	input wire logic [AW-1:0] eng_addr,
	output logic [COEF_W-1:0] eng_data
);

	// Buffer A and buffer B storage
	logic [COEF_W-1:0] buf_a [COEF_N];
	logic [COEF_W-1:0] buf_b [COEF_N];

	// Host read mux
	assign rd_data = (rd_buf == acs_pkg::ACS_BUF_B) ? buf_b[rd_addr] : buf_a[rd_addr];

	// Storage write; arrays carry no reset so they map onto RAM
	always_ff @(posedge clk)
	begin
		if (wr_en && wr_buf == acs_pkg::ACS_BUF_A)
			buf_a[wr_addr] <= wr_data;
		if (wr_en && wr_buf == acs_pkg::ACS_BUF_B)
			buf_b[wr_addr] <= wr_data;
	end

	// Engine read, one cycle latency
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			eng_data <= '0;
		else
			eng_data <= (eng_buf == acs_pkg::ACS_BUF_B) ? buf_b[eng_addr] : buf_a[eng_addr];
	end

endmodule : acs_coef_store

// ===== hw/acs_record_ctrl.sv
// Functional notes
// - Running, not adaptive: coefficient access blocked
// - Adaptive bit enables double-buffered coefficient updates
// - Every coefficient kept in two buffers
// - Swap request exchanges buffers at next sample
// - Swap request bit clears after exchange
// - In-use flag toggles per swap, shows buffer
// - Running adaptive: writes go to buffer not in use
// - Stopped: writes go to addressed buffer
// - Unused-input common mode off until software enables
// - Unrouted inputs high-impedance unless common mode on
// - Each divider takes ratios 1 to 128
// - Dividers run from shared root converter clock
`timescale 1ns/1ps
`include "acs_map.svh"

module acs_record_ctrl #(
	parameter int COEF_N = 64,
	parameter int COEF_W = 24,
	parameter int INPUTS = 6
) (
	// Clock and reset; clk is the root converter clock
	input wire logic clk,
	input wire logic rst_b,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [11:0] s_axi_awaddr,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [11:0] s_axi_araddr,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Filter engine coefficient port
	input wire logic [$clog2(COEF_N)-1:0] eng_coef_addr,
	output logic [COEF_W-1:0] eng_coef_data,
	// Converter timing
	output logic mod_tick,
	output logic sample_start,
	output logic record_running,
	output logic coef_in_use,
	// Analog input control
	input wire logic [INPUTS-1:0] input_routed,
	output logic [INPUTS-1:0] unused_input_cm_en,
	output logic [INPUTS-1:0] input_hiz
);

	localparam int AW = $clog2(COEF_N);

	// Divider code to ratio: code 0 stands for 128
	function automatic logic [7:0] div_ratio(input logic [6:0] code);
		div_ratio = (code == 7'h00) ? 8'h80 : {1'b0, code};
	endfunction : div_ratio

	// Coefficient window decode: page selects buffer, index must be in range
	function automatic logic coef_hit(input logic [11:0] addr);
		logic page_ok;
		page_ok = (addr[11:8] == `ACS_COEF_A_PAGE) || (addr[11:8] == `ACS_COEF_B_PAGE);
		coef_hit = page_ok && (32'(addr[7:2]) < COEF_N);
	endfunction : coef_hit

	// Control and status state
	logic run_reg;
	logic adapt_en_reg;
	logic swap_pend_reg;
	logic in_use_reg;
	logic [6:0] div1_reg;
	logic [6:0] div2_reg;
	logic [7:0] osr_reg;
	logic [5:0] ucm_reg;
	// Divider chain counters
	logic [7:0] cnt1_reg;
	logic [7:0] cnt2_reg;
	logic [8:0] cnt3_reg;
	// Write channel holding
	logic aw_held_reg;
	logic w_held_reg;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	// Read channel
	logic rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;

	// Access mode of the coefficient windows
	acs_pkg::acs_access_t acc_mode;
	assign acc_mode = !run_reg ? acs_pkg::ACS_ACC_DIRECT :
		(adapt_en_reg ? acs_pkg::ACS_ACC_REDIRECT : acs_pkg::ACS_ACC_LOCKED);

	// Write decode
	wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	wire wb0 = wstrb_reg[0];
	wire w_adapt = do_write && wb0 && awaddr_reg == `ACS_ADAPT_OFF;
	wire w_run = do_write && wb0 && awaddr_reg == `ACS_RUN_OFF;
	wire w_div1 = do_write && wb0 && awaddr_reg == `ACS_DIV1_OFF;
	wire w_div2 = do_write && wb0 && awaddr_reg == `ACS_DIV2_OFF;
	wire w_osr = do_write && wb0 && awaddr_reg == `ACS_OSR_OFF;
	wire w_ucm = do_write && wb0 && awaddr_reg == `ACS_UCM_OFF;
	wire w_coef_hit = coef_hit(awaddr_reg);
	wire w_ctrl_hit = awaddr_reg == `ACS_ADAPT_OFF || awaddr_reg == `ACS_RUN_OFF ||
		awaddr_reg == `ACS_DIV1_OFF || awaddr_reg == `ACS_DIV2_OFF ||
		awaddr_reg == `ACS_OSR_OFF || awaddr_reg == `ACS_UCM_OFF ||
		awaddr_reg == `ACS_STAT_OFF;
	// Coefficient words need their three low lanes together
	wire w_coef_full = &wstrb_reg[2:0];
	wire w_coef_ok = w_coef_hit && w_coef_full && acc_mode != acs_pkg::ACS_ACC_LOCKED;

	// Buffer named by the host address
	acs_pkg::acs_buf_t w_addr_buf;
	assign w_addr_buf = (awaddr_reg[11:8] == `ACS_COEF_B_PAGE) ?
		acs_pkg::ACS_BUF_B : acs_pkg::ACS_BUF_A;

	// Target buffer after redirection
	acs_pkg::acs_buf_t mem_wr_buf;
	always_comb
	begin
		mem_wr_buf = w_addr_buf;
		unique case (acc_mode)
			// Stopped: exactly the addressed buffer
			acs_pkg::ACS_ACC_DIRECT: mem_wr_buf = w_addr_buf;
			// Running adaptive: always the idle buffer
			acs_pkg::ACS_ACC_REDIRECT: mem_wr_buf = acs_pkg::acs_buf_t'(~in_use_reg);
			// Locked: no write happens, value irrelevant
			acs_pkg::ACS_ACC_LOCKED: mem_wr_buf = w_addr_buf;
			default: mem_wr_buf = w_addr_buf;
		endcase
	end
	wire mem_we = do_write && w_coef_ok;

	// Read decode
	wire ar_take = s_axi_arvalid && !rvalid_reg;
	wire r_coef_hit = coef_hit(s_axi_araddr);
	acs_pkg::acs_buf_t r_addr_buf;
	assign r_addr_buf = (s_axi_araddr[11:8] == `ACS_COEF_B_PAGE) ?
		acs_pkg::ACS_BUF_B : acs_pkg::ACS_BUF_A;
	logic [COEF_W-1:0] host_coef;

	// Register read mux
	logic [31:0] rd_word;
	logic rd_ok;
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		if (r_coef_hit)
		begin
			// Blocked reads return zero with an error
			rd_ok = (acc_mode != acs_pkg::ACS_ACC_LOCKED);
			rd_word = rd_ok ? 32'(host_coef) : 32'h0000_0000;
		end
		else if (s_axi_araddr == `ACS_ADAPT_OFF)
			rd_word = {29'h0, adapt_en_reg, in_use_reg, swap_pend_reg};
		else if (s_axi_araddr == `ACS_RUN_OFF)
			rd_word = {31'h0, run_reg};
		else if (s_axi_araddr == `ACS_DIV1_OFF)
			rd_word = {25'h0, div1_reg};
		else if (s_axi_araddr == `ACS_DIV2_OFF)
			rd_word = {25'h0, div2_reg};
		else if (s_axi_araddr == `ACS_OSR_OFF)
			rd_word = {24'h0, osr_reg};
		else if (s_axi_araddr == `ACS_UCM_OFF)
			rd_word = {24'h0, ucm_reg, 2'h0};
		else if (s_axi_araddr == `ACS_STAT_OFF)
			rd_word = {30'h0, acc_mode == acs_pkg::ACS_ACC_LOCKED, run_reg};
		else
			rd_ok = 1'b0;
	end

	// Coefficient storage
	acs_coef_store #(
		.COEF_N(COEF_N),
		.COEF_W(COEF_W),
		.AW(AW)
	) u_store (
		.clk(clk),
		.rst_b(rst_b),
		.wr_en(mem_we),
		.wr_buf(mem_wr_buf),
		.wr_addr(awaddr_reg[AW+1:2]),
		.wr_data(wdata_reg[COEF_W-1:0]),
		.rd_buf(r_addr_buf),
		.rd_addr(s_axi_araddr[AW+1:2]),
		.rd_data(host_coef),
		.eng_buf(acs_pkg::acs_buf_t'(in_use_reg)),
		.eng_addr(eng_coef_addr),
		.eng_data(eng_coef_data)
	);

	// Divider chain terminal counts; ratios 1..128 each, OSR 0 means 256
	wire [7:0] ratio1 = div_ratio(div1_reg);
	wire [7:0] ratio2 = div_ratio(div2_reg);
	wire [8:0] ratio3 = (osr_reg == 8'h00) ? 9'h100 : {1'b0, osr_reg};
	wire tick1 = run_reg && (cnt1_reg == ratio1 - 8'h01);
	wire tick2 = tick1 && (cnt2_reg == ratio2 - 8'h01);
	wire tick3 = tick2 && (cnt3_reg == ratio3 - 9'h001);

	// Divider counters on the shared root clock, held at zero while stopped
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt1_reg <= 8'h00;
			cnt2_reg <= 8'h00;
			cnt3_reg <= 9'h000;
		end
		else if (!run_reg)
		begin
			cnt1_reg <= 8'h00;
			cnt2_reg <= 8'h00;
			cnt3_reg <= 9'h000;
		end
		else
		begin
			cnt1_reg <= tick1 ? 8'h00 : cnt1_reg + 8'h01;
			if (tick1)
				cnt2_reg <= tick2 ? 8'h00 : cnt2_reg + 8'h01;
			if (tick2)
				cnt3_reg <= tick3 ? 9'h000 : cnt3_reg + 9'h001;
		end
	end

	// Swap happens at a sample boundary only while running adaptive
	wire swap_now = swap_pend_reg && tick3 && adapt_en_reg && run_reg;
	wire swap_set = w_adapt && wdata_reg[`ACS_SWAP_BIT] && adapt_en_reg && run_reg;
	// Pending is dropped if adaptive mode or the converter goes away
	wire swap_drop = !adapt_en_reg || !run_reg;
	wire swap_pend_next = swap_set ? 1'b1 : ((swap_now || swap_drop) ? 1'b0 : swap_pend_reg);

	// Adaptive control, swap and in-use flag
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			adapt_en_reg <= 1'b0;
			swap_pend_reg <= 1'b0;
			in_use_reg <= 1'b0;
		end
		else
		begin
			if (w_adapt)
				adapt_en_reg <= wdata_reg[`ACS_ADAPT_BIT];
			// A new request wins over the self-clear
			swap_pend_reg <= swap_pend_next;
			if (swap_now)
				in_use_reg <= ~in_use_reg;
		end
	end

	// Plain configuration registers
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			run_reg <= 1'b0;
			div1_reg <= `ACS_DIV_RST;
			div2_reg <= `ACS_DIV_RST;
			osr_reg <= `ACS_OSR_RST;
			ucm_reg <= `ACS_UCM_RST;
		end
		else
		begin
			if (w_run)
				run_reg <= wdata_reg[0];
			if (w_div1)
				div1_reg <= wdata_reg[6:0];
			if (w_div2)
				div2_reg <= wdata_reg[6:0];
			if (w_osr)
				osr_reg <= wdata_reg[7:0];
			if (w_ucm)
				ucm_reg <= wdata_reg[`ACS_UCM_MSB:`ACS_UCM_LSB];
		end
	end

	// Write channel: address and data are taken in either order
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 12'h000;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `ACS_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= {s_axi_awaddr[11:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= (w_ctrl_hit || w_coef_ok) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
			end
			else if (bvalid_reg && s_axi_bready)
				bvalid_reg <= 1'b0;
		end
	end

	// Read channel: one word per request, answered on the next edge
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `ACS_RESP_OKAY;
		end
		else if (ar_take)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_word;
			rresp_reg <= rd_ok ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
		end
		else if (rvalid_reg && s_axi_rready)
			rvalid_reg <= 1'b0;
	end

	// Bus handshake outputs
	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready = !w_held_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// Converter and analog outputs
	assign mod_tick = tick2;
	assign sample_start = tick3;
	assign record_running = run_reg;
	assign coef_in_use = in_use_reg;
	assign unused_input_cm_en = ucm_reg[INPUTS-1:0];
	// Floating pins charge with a thump when routed later, hence the option
	assign input_hiz = ~input_routed & ~unused_input_cm_en;

	// Checks
	AST_LOCK_BLOCKS: assert property (@(posedge clk) disable iff (!rst_b)
		(run_reg && !adapt_en_reg) |-> !mem_we)
		else $error("coefficient write while locked");
	AST_ADAPT_SET: assert property (@(posedge clk) disable iff (!rst_b)
		w_adapt |=> (adapt_en_reg == $past(wdata_reg[`ACS_ADAPT_BIT])))
		else $error("adaptive bit not taken");
	AST_SWAP_AT_SAMPLE: assert property (@(posedge clk) disable iff (!rst_b)
		(in_use_reg != $past(in_use_reg)) |-> ($past(tick3) && $past(swap_pend_reg)))
		else $error("buffer swap off a sample boundary");
	AST_SWAP_SELF_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
		(swap_now && !swap_set) |=> !swap_pend_reg)
		else $error("swap request not cleared");
	AST_FLAG_TOGGLE: assert property (@(posedge clk) disable iff (!rst_b)
		swap_now |=> (in_use_reg == !$past(in_use_reg)))
		else $error("in-use flag did not toggle");
	AST_REDIRECT: assert property (@(posedge clk) disable iff (!rst_b)
		(mem_we && run_reg) |-> (mem_wr_buf != in_use_reg))
		else $error("running write hit active buffer");
	AST_DIRECT: assert property (@(posedge clk) disable iff (!rst_b)
		(mem_we && !run_reg) |-> (mem_wr_buf == (awaddr_reg[11:8] == `ACS_COEF_B_PAGE)))
		else $error("stopped write redirected");
	AST_HIZ: assert property (@(posedge clk) disable iff (!rst_b)
		(!input_routed[0] && !unused_input_cm_en[0]) |-> input_hiz[0])
		else $error("unrouted input not high impedance");
	AST_DIV1_PERIOD: assert property (@(posedge clk) disable iff (!rst_b)
		tick1 |=> (cnt1_reg == 8'h00))
		else $error("first divider period wrong");
	AST_NO_SWAP_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
		(!(adapt_en_reg && run_reg)) |=> $stable(in_use_reg))
		else $error("swap while not adaptive");

	// Scenario coverage
	COV_SWAP: cover property (@(posedge clk) disable iff (!rst_b) swap_now);
	COV_REDIRECT: cover property (@(posedge clk) disable iff (!rst_b)
		mem_we && run_reg && mem_wr_buf != w_addr_buf);
	COV_LOCKED_WRITE: cover property (@(posedge clk) disable iff (!rst_b)
		do_write && w_coef_hit && acc_mode == acs_pkg::ACS_ACC_LOCKED);
	COV_SET_BEATS_CLEAR: cover property (@(posedge clk) disable iff (!rst_b)
		swap_now && swap_set);

endmodule : acs_record_ctrl

// ===== tb/adc_coef_swap_and_setup_bench.sv
`timescale 1ns/1ps
`include "acs_map.svh"

// Compare one value against its expectation and count the result
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fail_count++; \
	$display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end

module adc_coef_swap_and_setup_bench;

	// Clock, reset and bus signals; the bench drives awvalid, wvalid, arvalid, addresses, data, strobes, bready and rready, the controller the rest
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [31:0] s_axi_wdata = 32'h00000000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b1;
	logic [1:0] s_axi_bresp;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [11:0] s_axi_araddr = 12'h000;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b1;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	// Engine and analog side
	logic [5:0] eng_coef_addr = 6'h04;
	logic [23:0] eng_coef_data;
	logic mod_tick;
	logic sample_start;
	logic record_running;
	logic coef_in_use;
	logic [5:0] input_routed = 6'h05;
	logic [5:0] unused_input_cm_en;
	logic [5:0] input_hiz;
	// Bookkeeping
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	int p;

	// Coefficient slot 4 in each buffer window
	localparam logic [11:0] CA4 = 12'h110;
	localparam logic [11:0] CB4 = 12'h210;

	always #20 clk = ~clk;

	acs_record_ctrl uut (
		.clk(clk), .rst_b(rst_b),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.eng_coef_addr(eng_coef_addr), .eng_coef_data(eng_coef_data), .mod_tick(mod_tick),
		.sample_start(sample_start), .record_running(record_running), .coef_in_use(coef_in_use),
		.input_routed(input_routed), .unused_input_cm_en(unused_input_cm_en),
		.input_hiz(input_hiz)
	);

	// Verdict and end of run
	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	// Hang guard; the whole sequence needs well under a thousand cycles
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			wrap_up();
		end
	end

	// Write one word; handshakes are judged mid-cycle and acted on at the next rising edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic awt, wt, bt;
		logic [1:0] br;
		bt = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!bt)
		begin
			@(negedge clk);
			awt = s_axi_awvalid & s_axi_awready;
			wt = s_axi_wvalid & s_axi_wready;
			bt = s_axi_bvalid & s_axi_bready;
			br = s_axi_bresp;
			@(posedge clk);
			if (awt) s_axi_awvalid <= 1'b0;
			if (wt) s_axi_wvalid <= 1'b0;
		end
		`CHK("bresp", er, br)
	endtask : wr

	// Read one word and compare data and response
	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic art, rt;
		logic [31:0] dd;
		logic [1:0] rr;
		rt = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (!rt)
		begin
			@(negedge clk);
			art = s_axi_arvalid & s_axi_arready;
			rt = s_axi_rvalid & s_axi_rready;
			dd = s_axi_rdata;
			rr = s_axi_rresp;
			@(posedge clk);
			if (art) s_axi_arvalid <= 1'b0;
		end
		`CHK("rresp", er, rr)
		`CHK("rdata", ed, dd)
	endtask : rd

	// Program the dividers while stopped, restart, and measure the sample spacing
	task automatic cfg_period(input logic [6:0] d1, input logic [6:0] d2, input logic [7:0] os,
		input int ex);
		wr(`ACS_RUN_OFF, 32'h0, `ACS_RESP_OKAY);
		wr(`ACS_DIV1_OFF, {25'h0, d1}, `ACS_RESP_OKAY);
		wr(`ACS_DIV2_OFF, {25'h0, d2}, `ACS_RESP_OKAY);
		wr(`ACS_OSR_OFF, {24'h0, os}, `ACS_RESP_OKAY);
		wr(`ACS_RUN_OFF, 32'h1, `ACS_RESP_OKAY);
		do @(negedge clk); while (!sample_start);
		`CHK("mod_tick", 1'b1, mod_tick)
		`CHK("running", 1'b1, record_running)
		p = 0;
		do
		begin
			@(negedge clk);
			p++;
		end
		while (!sample_start);
		`CHK("sample_period", ex, p)
		@(posedge clk);
	endtask : cfg_period

	// Request just after a boundary so the exchange lands at the next one; the write takes
	// three edges, so this relies on a sample period of four cycles
	task automatic swap_check(input logic old, input logic [23:0] eng_ex);
		do @(negedge clk); while (!sample_start);
		@(posedge clk);
		wr(`ACS_ADAPT_OFF, 32'h5, `ACS_RESP_OKAY);
		do @(negedge clk); while (!sample_start);
		`CHK("in_use_before", old, coef_in_use)
		@(negedge clk);
		`CHK("in_use_after", ~old, coef_in_use)
		@(negedge clk);
		@(negedge clk);
		`CHK("eng_coef_data", eng_ex, eng_coef_data)
		@(posedge clk);
	endtask : swap_check

	// Main sequence
	initial
	begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		// Reset state
		@(negedge clk);
		`CHK("in_use_reset", 1'b0, coef_in_use)
		`CHK("hiz_reset", 6'h3A, input_hiz)
		@(posedge clk);
		rd(`ACS_ADAPT_OFF, 32'h0, `ACS_RESP_OKAY);
		rd(`ACS_UCM_OFF, 32'h0, `ACS_RESP_OKAY);
		rd(`ACS_DIV1_OFF, 32'h1, `ACS_RESP_OKAY);
		rd(`ACS_OSR_OFF, 32'h40, `ACS_RESP_OKAY);
		// Common-mode tie-off for inputs 0 and 1 only
		wr(`ACS_UCM_OFF, 32'h0C, `ACS_RESP_OKAY);
		@(negedge clk);
		`CHK("cm_en", 6'h03, unused_input_cm_en)
		`CHK("hiz_cm", 6'h38, input_hiz)
		@(posedge clk);
		// Route the upper inputs; only unrouted ones without tie-off float
		input_routed <= 6'h30;
		@(negedge clk);
		`CHK("hiz_routed", 6'h0C, input_hiz)
		@(posedge clk);
		wr(`ACS_UCM_OFF, 32'h0, `ACS_RESP_OKAY);
		// Stopped: each write reaches the addressed copy
		wr(CA4, 32'h111111, `ACS_RESP_OKAY);
		wr(CB4, 32'h222222, `ACS_RESP_OKAY);
		rd(CA4, 32'h111111, `ACS_RESP_OKAY);
		rd(CB4, 32'h222222, `ACS_RESP_OKAY);
		rd(12'hFF0, 32'h0, `ACS_RESP_SLVERR);
		// Divider range ends, code 0 meaning 128
		cfg_period(7'h00, 7'h01, 8'h01, 128);
		cfg_period(7'h01, 7'h00, 8'h01, 128);
		cfg_period(7'h01, 7'h01, 8'h04, 4);
		// Running, adaptive off: coefficients locked
		rd(CA4, 32'h0, `ACS_RESP_SLVERR);
		wr(CA4, 32'h333333, `ACS_RESP_SLVERR);
		rd(`ACS_STAT_OFF, 32'h3, `ACS_RESP_OKAY);
		// Swap request without adaptive mode is ignored
		wr(`ACS_ADAPT_OFF, 32'h1, `ACS_RESP_OKAY);
		repeat (12) @(posedge clk);
		rd(`ACS_ADAPT_OFF, 32'h0, `ACS_RESP_OKAY);
		// Adaptive on: write to A lands in idle B
		wr(`ACS_ADAPT_OFF, 32'h4, `ACS_RESP_OKAY);
		wr(CA4, 32'h444444, `ACS_RESP_OKAY);
		rd(CB4, 32'h444444, `ACS_RESP_OKAY);
		rd(CA4, 32'h111111, `ACS_RESP_OKAY);
		@(negedge clk);
		`CHK("eng_before_swap", 24'h111111, eng_coef_data)
		@(posedge clk);
		swap_check(1'b0, 24'h444444);
		rd(`ACS_ADAPT_OFF, 32'h6, `ACS_RESP_OKAY);
		// Now B is in use: write to B lands in A
		wr(CB4, 32'h555555, `ACS_RESP_OKAY);
		rd(CA4, 32'h555555, `ACS_RESP_OKAY);
		rd(CB4, 32'h444444, `ACS_RESP_OKAY);
		swap_check(1'b1, 24'h555555);
		rd(`ACS_ADAPT_OFF, 32'h4, `ACS_RESP_OKAY);
		// Stopped: swap request has no effect, writes are direct again
		wr(`ACS_RUN_OFF, 32'h0, `ACS_RESP_OKAY);
		wr(`ACS_ADAPT_OFF, 32'h5, `ACS_RESP_OKAY);
		repeat (12) @(posedge clk);
		@(negedge clk);
		`CHK("in_use_stopped", 1'b0, coef_in_use)
		@(posedge clk);
		wr(CA4, 32'h666666, `ACS_RESP_OKAY);
		rd(CA4, 32'h666666, `ACS_RESP_OKAY);
		rd(CB4, 32'h444444, `ACS_RESP_OKAY);
		// Mid-run reset must drop adaptive mode again
		rst_b <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rd(`ACS_ADAPT_OFF, 32'h0, `ACS_RESP_OKAY);
		wrap_up();
	end

endmodule : adc_coef_swap_and_setup_bench
